/* File: prad_decode.v */
`timescale 1ns/1ps
`default_nettype none
`include "prad_regs.vh"
// Combinational offset decoder and access-legality check
module prad_decode (
	input wire [12:0] offset_in,
	input wire [1:0] size_in,
	input wire [3:0] strobe_in,
	input wire burst_in,
	output reg [2:0] target_out,
	output reg error_out
);
	function in_range;
		input [12:0] off;
		input [12:0] lo;
		input [12:0] hi;
		begin
			in_range = (off >= lo) && (off <= hi);
		end
	endfunction

	// Target selection by offset window
	always @* begin
		target_out = `PRAD_TGT_NONE;
		if (in_range(offset_in, `PRAD_SCU_LO, `PRAD_SCU_HI)) begin
			target_out = `PRAD_TGT_SCU;
		end else if (in_range(offset_in, `PRAD_IFC_LO, `PRAD_IFC_HI)) begin
			target_out = `PRAD_TGT_IFC;
		end else if (in_range(offset_in, `PRAD_GTM_LO, `PRAD_GTM_HI)) begin
			target_out = `PRAD_TGT_GTM;
		end else if (in_range(offset_in, `PRAD_PTM_LO, `PRAD_PTM_HI)) begin
			target_out = `PRAD_TGT_PTM;
		end else if (in_range(offset_in, `PRAD_DST_LO, `PRAD_DST_HI)) begin
			target_out = `PRAD_TGT_DST;
		end else begin
			target_out = `PRAD_TGT_RSV;
		end
	end

	// Legality of size, strobes and burst per target
	always @* begin
		error_out = 1'b0;
		if (burst_in) begin
			error_out = 1'b1;
		end else if (size_in == `PRAD_SZ_HALF || size_in == `PRAD_SZ_DWORD) begin
			error_out = 1'b1;
		end else if (size_in == `PRAD_SZ_WORD) begin
			if (strobe_in != 4'hf && target_out != `PRAD_TGT_RSV && target_out != `PRAD_TGT_NONE) begin
				error_out = 1'b1;
			end
		end else begin
			if (target_out == `PRAD_TGT_GTM || target_out == `PRAD_TGT_PTM) begin
				error_out = 1'b1;
			end
		end
	end
endmodule // prad_decode
`default_nettype wire

/* File: prad_lanes.v */
`timescale 1ns/1ps
`default_nettype none
// Little-endian byte lane placement for write data and read return
module prad_lanes (
	input wire [1:0] byte_addr_in,
	input wire [1:0] size_in,
	input wire [31:0] wdata_in,
	input wire [31:0] rdata_in,
	output reg [31:0] wdata_out,
	output reg [31:0] rdata_out
);
	// Byte N of write word sits at bits 8N+7:8N only; read byte N returns at bits 7:0
	always @* begin
		wdata_out = wdata_in;
		rdata_out = rdata_in;
		if (size_in == 2'h0) begin
			wdata_out = {24'h000000, wdata_in[7:0]} << {byte_addr_in, 3'h0};
			rdata_out = {24'h000000, rdata_in[8*byte_addr_in +: 8]};
		end
	end
endmodule // prad_lanes
`default_nettype wire

/* File: prad_region_decoder.v */
`timescale 1ns/1ps
`default_nettype none
`include "prad_regs.vh"
// Operation
// - Two adjacent 4KB pages on private bus
// - Region base from base pins 31:13
// - Little-endian lane order only
// - Multiple transfers aborted with slave error
// - Timers and watchdogs accept word only
// - Halfword and doubleword aborted with error
// - Partial-strobe word aborted with error, except in reserved space
// - Coherency port never reaches region
// - 0x0000-0x00fc to coherency unit
// - 0x0100-0x01ff to interrupt interfaces
// - 0x0200-0x02ff to global timer
// - 0x0600-0x06ff to private timers
// - 0x1000-0x1fff to interrupt distributor
// - Reserved halfword/doubleword answered with error
// - Reserved byte/word completes without error
// - Per-core active-low normal and fast interrupts
// - Up to 224 external interrupt inputs
module prad_region_decoder #(
	parameter NUM_CORES = 4,
	parameter NUM_EXT_IRQ = 224
) (
	input wire clk_in,
	input wire rst_b_in,
	input wire [18:0] private_region_base_pins_in,
	input wire req_valid_in,
	input wire req_write_in,
	input wire [31:0] req_addr_in,
	input wire [1:0] req_size_in,
	input wire [3:0] req_strobe_in,
	input wire req_burst_in,
	input wire req_from_acp_in,
	input wire [31:0] req_wdata_in,
	output wire req_ready_out,
	output reg resp_valid_out,
	output reg [1:0] resp_code_out,
	output reg [31:0] resp_rdata_out,
	output reg resp_hit_out,
	output reg tgt_valid_out,
	output reg [2:0] tgt_select_out,
	output reg tgt_write_out,
	output reg [11:0] tgt_offset_out,
	output reg [3:0] tgt_strobe_out,
	output reg [31:0] tgt_wdata_out,
	input wire tgt_done_in,
	input wire [31:0] tgt_rdata_in,
	input wire [NUM_EXT_IRQ-1:0] ext_irq_in,
	input wire [NUM_CORES-1:0] core_irq_req_in,
	input wire [NUM_CORES-1:0] core_fiq_req_in,
	output reg [NUM_CORES-1:0] legacy_normal_interrupt_n_out,
	output reg [NUM_CORES-1:0] legacy_fast_interrupt_n_out,
	output reg [NUM_EXT_IRQ-1:0] ext_irq_sync_out
);
	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_RESP = 2'h2;

	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [1:0] size_reg;
	reg [1:0] byte_addr_reg;
	reg [31:0] wdata_raw_reg;
	reg [NUM_EXT_IRQ-1:0] irq_s1_reg;
	reg [NUM_EXT_IRQ-1:0] irq_s2_reg;
	reg [NUM_EXT_IRQ-1:0] irq_s3_reg;
	wire region_hit;
	wire [2:0] dec_target;
	wire dec_error;
	wire [31:0] lane_wdata;
	wire [31:0] lane_rdata;

	// Base compare on upper 19 bits; coherency port excluded
	assign region_hit = (req_addr_in[31:`PRAD_BASE_LSB] == private_region_base_pins_in)
		&& !req_from_acp_in;
	assign req_ready_out = (state_reg == ST_IDLE);

	prad_decode u_decode (
		.offset_in(req_addr_in[12:0]),
		.size_in(req_size_in),
		.strobe_in(req_strobe_in),
		.burst_in(req_burst_in),
		.target_out(dec_target),
		.error_out(dec_error)
	);

	prad_lanes u_lanes (
		.byte_addr_in(byte_addr_reg),
		.size_in(size_reg),
		.wdata_in(wdata_raw_reg),
		.rdata_in(tgt_rdata_in),
		.wdata_out(lane_wdata),
		.rdata_out(lane_rdata)
	);

	// Next-state logic of the access sequencer
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (req_valid_in && region_hit) begin
					if (dec_error || dec_target == `PRAD_TGT_RSV) begin
						state_next = ST_RESP;
					end else begin
						state_next = ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				if (tgt_done_in) begin
					state_next = ST_RESP;
				end
			end
			ST_RESP: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// Sequencer, target strobe and response registers
	always @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_reg <= ST_IDLE;
			size_reg <= 2'h0;
			byte_addr_reg <= 2'h0;
			wdata_raw_reg <= 32'h00000000;
			resp_valid_out <= 1'b0;
			resp_code_out <= `PRAD_RESP_OKAY;
			resp_rdata_out <= 32'h00000000;
			resp_hit_out <= 1'b0;
			tgt_valid_out <= 1'b0;
			tgt_select_out <= `PRAD_TGT_NONE;
			tgt_write_out <= 1'b0;
			tgt_offset_out <= 12'h000;
			tgt_strobe_out <= 4'h0;
			tgt_wdata_out <= 32'h00000000;
		end else begin
			state_reg <= state_next;
			resp_valid_out <= 1'b0;
			if (state_reg == ST_IDLE && req_valid_in) begin
				resp_hit_out <= region_hit;
				size_reg <= req_size_in;
				byte_addr_reg <= req_addr_in[1:0];
				tgt_select_out <= dec_target;
				tgt_write_out <= req_write_in;
				tgt_offset_out <= req_addr_in[11:0];
				tgt_strobe_out <= req_strobe_in;
				tgt_wdata_out <= req_wdata_in;
				wdata_raw_reg <= req_wdata_in; // Held so lane placement never sees later bus data
				if (region_hit && dec_error) begin
					resp_code_out <= `PRAD_RESP_SLVERR;
				end else begin
					resp_code_out <= `PRAD_RESP_OKAY;
				end
				if (region_hit && !dec_error && dec_target != `PRAD_TGT_RSV) begin
					tgt_valid_out <= 1'b1;
				end
			end
			if (state_reg == ST_WAIT) begin
				tgt_wdata_out <= lane_wdata;
				if (tgt_done_in) begin
					tgt_valid_out <= 1'b0;
					resp_rdata_out <= lane_rdata;
				end
			end
			if (state_reg == ST_RESP) begin
				resp_valid_out <= 1'b1;
				if (tgt_select_out == `PRAD_TGT_RSV) begin
					resp_rdata_out <= 32'h00000000;
				end
			end
		end
	end

	// Legacy per-core interrupt lines, active low
	always @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			legacy_normal_interrupt_n_out <= {NUM_CORES{1'b1}};
			legacy_fast_interrupt_n_out <= {NUM_CORES{1'b1}};
		end else begin
			legacy_normal_interrupt_n_out <= ~core_irq_req_in;
			legacy_fast_interrupt_n_out <= ~core_fiq_req_in;
		end
	end

	// External interrupt inputs synchronised, change taken when stages agree
	always @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			irq_s1_reg <= {NUM_EXT_IRQ{1'b0}};
			irq_s2_reg <= {NUM_EXT_IRQ{1'b0}};
			irq_s3_reg <= {NUM_EXT_IRQ{1'b0}};
			ext_irq_sync_out <= {NUM_EXT_IRQ{1'b0}};
		end else begin
			irq_s1_reg <= ext_irq_in;
			irq_s2_reg <= irq_s1_reg;
			irq_s3_reg <= irq_s2_reg;
			ext_irq_sync_out <= (irq_s2_reg & irq_s3_reg) | (ext_irq_sync_out & (irq_s2_reg | irq_s3_reg));
		end
	end
endmodule // prad_region_decoder
`default_nettype wire

/* File: prad_region_decoder_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// Access checks at the decoder ports
module prad_props #(parameter NUM_CORES = 4) (
	input wire logic clk_in, rst_b_in, req_valid_in, req_ready_out, req_burst_in, req_from_acp_in,
	input wire logic resp_valid_out, resp_hit_out, tgt_valid_out,
	input wire logic [18:0] private_region_base_pins_in,
	input wire logic [31:0] req_addr_in,
	input wire logic [1:0] req_size_in, resp_code_out,
	input wire logic [3:0] req_strobe_in,
	input wire logic [2:0] tgt_select_out,
	input wire logic [NUM_CORES-1:0] core_irq_req_in, legacy_normal_interrupt_n_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	wire logic [12:0] off = req_addr_in[12:0];
	wire logic acc = req_valid_in && req_ready_out;
	wire logic hit = acc && !req_from_acp_in && req_addr_in[31:13] == private_region_base_pins_in;
	// Abort answered two cycles after accept
	sequence err2; ##2 resp_valid_out && resp_code_out == 2'h2; endsequence
	a_burst_abort: assert property (hit && req_burst_in |-> err2)
		else $error("burst not aborted");
	a_half_abort: assert property (hit && req_size_in == 2'h1 |-> err2)
		else $error("halfword not aborted");
	a_strobe_abort: assert property (hit && req_size_in == 2'h2 && req_strobe_in != 4'hf && off < 13'h0300 |-> err2)
		else $error("partial strobe not aborted");
	a_timer_byte: assert property (hit && req_size_in == 2'h0 && off[12:8] == 5'h06 |-> err2)
		else $error("timer byte not aborted");
	a_port_miss: assert property (acc && req_from_acp_in |=> !resp_hit_out ##1 !resp_valid_out)
		else $error("port request hit region");
	a_timer_route: assert property (hit && !req_burst_in && req_size_in == 2'h2 && req_strobe_in == 4'hf &&
		off[12:8] == 5'h02 |=> tgt_valid_out && tgt_select_out == 3'h3)
		else $error("timer not selected");
	a_rsv_okay: assert property (hit && !req_burst_in && req_size_in == 2'h0 && off[12:8] >= 5'h07 &&
		off < 13'h1000 |-> ##1 !tgt_valid_out ##1 resp_valid_out && resp_code_out == 2'h0)
		else $error("reserved byte not completed");
	a_irq_invert: assert property ($past(rst_b_in) |-> legacy_normal_interrupt_n_out == ~$past(core_irq_req_in))
		else $error("interrupt line not inverted");
endmodule // prad_props
bind prad_region_decoder prad_props #(.NUM_CORES(NUM_CORES)) u_props (.clk_in, .rst_b_in, .req_valid_in,
	.req_ready_out, .req_burst_in, .req_from_acp_in, .resp_valid_out, .resp_hit_out, .tgt_valid_out,
	.private_region_base_pins_in, .req_addr_in, .req_size_in, .resp_code_out, .req_strobe_in, .tgt_select_out,
	.core_irq_req_in, .legacy_normal_interrupt_n_out);
`default_nettype wire

/* File: prad_region_decoder_test.sv */
`timescale 1ns/1ps
`default_nettype none
module prad_region_decoder_test;
	localparam logic [18:0] BASE = 19'h2a5c3;
	logic clk_in = 0, rst_b_in = 0, req_valid_in = 0, req_write_in = 0, req_burst_in = 0, req_from_acp_in = 0;
	logic [31:0] req_addr_in = 0, req_wdata_in = 0;
	logic [1:0] req_size_in = 0;
	logic [3:0] req_strobe_in = 0, core_irq_req_in = 0, core_fiq_req_in = 0, dly = 0;
	logic [223:0] ext_irq_in = 0;
	wire logic req_ready_out, resp_valid_out, resp_hit_out, tgt_valid_out, tgt_done_in, tgt_write_out;
	wire logic [3:0] tgt_strobe_out;
	wire logic [31:0] tgt_wdata_out;
	wire logic [223:0] ext_irq_sync_out;
	wire logic [1:0] resp_code_out;
	wire logic [2:0] tgt_select_out;
	wire logic [3:0] legacy_normal_interrupt_n_out, legacy_fast_interrupt_n_out;
	wire logic [11:0] tgt_offset_out;
	wire logic [31:0] resp_rdata_out, tgt_rdata_in;
	int err_count = 0, n_compared = 0, cycles = 0;
	prad_region_decoder u_dut (.clk_in, .rst_b_in, .private_region_base_pins_in(BASE), .req_valid_in,
		.req_write_in, .req_addr_in, .req_size_in, .req_strobe_in, .req_burst_in, .req_from_acp_in, .req_wdata_in,
		.req_ready_out, .resp_valid_out, .resp_code_out, .resp_rdata_out, .resp_hit_out, .tgt_valid_out,
		.tgt_select_out, .tgt_write_out, .tgt_offset_out, .tgt_strobe_out, .tgt_wdata_out, .tgt_done_in,
		.tgt_rdata_in, .ext_irq_in, .core_irq_req_in, .core_fiq_req_in, .legacy_normal_interrupt_n_out,
		.legacy_fast_interrupt_n_out, .ext_irq_sync_out);
	prad_tgt_model u_tgt (.clk_in, .rst_b_in, .valid_in(tgt_valid_out), .offset_in(tgt_offset_out),
		.delay_in(dly), .done_out(tgt_done_in), .rdata_out(tgt_rdata_in));
	// 40 MHz clock
	always #12.5 clk_in = ~clk_in;
	// Hang guard
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 4000) begin
			err_count++;
			results();
		end
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task results;
		if (err_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// One transfer at region offset o; reads when bit 2 clear
	task x(input logic [31:0] o, input logic [1:0] sz, input logic [3:0] st, input logic [1:0] ec,
		input logic [2:0] es);
		logic [2:0] sel;
		logic got;
		logic eh;
		sel = 3'h0;
		got = 1'b0;
		eh = !req_from_acp_in && o < 32'h2000;
		@(negedge clk_in);
		req_valid_in = 1'b1;
		req_write_in = o[2];
		req_addr_in = {BASE, 13'h0} + o;
		req_wdata_in = o;
		req_size_in = sz;
		req_strobe_in = st;
		@(negedge clk_in);
		req_valid_in = 1'b0;
		chk("hit", resp_hit_out, eh);
		repeat (12) begin
			if (tgt_valid_out) begin
				sel = tgt_select_out;
				chk("twr", tgt_write_out, o[2]);
				chk("toff", tgt_offset_out, o[11:0]);
				chk("tstb", tgt_strobe_out, st);
				if (sz == 2'h2)
					chk("twd", tgt_wdata_out, o);
			end
			if (resp_valid_out && !got) begin
				got = 1'b1;
				chk("code", resp_code_out, ec);
				if (!o[2] && ec == 2'h0)
					chk("rdata", resp_rdata_out, es ? {20'h5a5a0, o[11:0]} : 32'h0);
			end
			@(negedge clk_in);
		end
		chk("resp", got, eh);
		chk("sel", sel, es);
	endtask
	task t_routes;
		logic [12:0] o [8] = '{13'h0000, 13'h00fc, 13'h0100, 13'h01fc, 13'h0200, 13'h06f8, 13'h1000, 13'h1ffc};
		logic [2:0] s [8] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h5, 3'h5};
		for (int i = 0; i < 8; i++) begin
			dly = 4'(i);
			x(o[i], 2'h2, 4'hf, 2'h0, s[i]);
		end
	endtask
	task t_errors;
		req_burst_in = 1'b1;
		x(13'h0200, 2'h2, 4'hf, 2'h2, 3'h0);
		req_burst_in = 1'b0;
		x(13'h0100, 2'h1, 4'h3, 2'h2, 3'h0);
		x(13'h1008, 2'h3, 4'hf, 2'h2, 3'h0);
		x(13'h0004, 2'h2, 4'h7, 2'h2, 3'h0);
		x(13'h0204, 2'h0, 4'h1, 2'h2, 3'h0);
		x(13'h0600, 2'h0, 4'h1, 2'h2, 3'h0);
	endtask
	task t_reserved;
		x(13'h0300, 2'h0, 4'h1, 2'h0, 3'h0);
		x(13'h05fc, 2'h2, 4'hf, 2'h0, 3'h0);
		x(13'h0400, 2'h3, 4'hf, 2'h2, 3'h0);
		x(13'h0700, 2'h2, 4'hf, 2'h0, 3'h0);
		x(13'h0ffd, 2'h0, 4'h2, 2'h0, 3'h0);
		x(13'h0800, 2'h1, 4'h3, 2'h2, 3'h0);
	endtask
	task t_miss;
		req_from_acp_in = 1'b1;
		x(13'h0200, 2'h2, 4'hf, 2'h0, 3'h0);
		req_from_acp_in = 1'b0;
		x(32'h2000, 2'h2, 4'hf, 2'h0, 3'h0);
	endtask
	task t_irq;
		@(negedge clk_in);
		core_irq_req_in = 4'h5;
		core_fiq_req_in = 4'ha;
		repeat (2) @(negedge clk_in);
		chk("irq", legacy_normal_interrupt_n_out, 4'ha);
		chk("fiq", legacy_fast_interrupt_n_out, 4'h5);
	endtask
	// One-cycle glitch filtered; steady level passes after stages agree
	task t_ext;
		@(negedge clk_in);
		ext_irq_in[5] = 1'b1;
		@(negedge clk_in);
		ext_irq_in[5] = 1'b0;
		repeat (5) @(negedge clk_in);
		chk("glitch", ext_irq_sync_out[5], 1'b0);
		ext_irq_in[7] = 1'b1;
		repeat (2) @(negedge clk_in);
		chk("early", ext_irq_sync_out[7], 1'b0);
		repeat (2) @(negedge clk_in);
		chk("ext", ext_irq_sync_out[7], 1'b1);
	endtask
	// Reset, then scenarios
	initial begin
		repeat (6) @(negedge clk_in);
		rst_b_in = 1'b1;
		t_routes();
		t_errors();
		t_reserved();
		t_miss();
		t_irq();
		t_ext();
		results();
	end
endmodule // prad_region_decoder_test
`default_nettype wire

/* File: prad_regs.vh */
`ifndef PRAD_REGS_VH
`define PRAD_REGS_VH
// Region geometry
`define PRAD_BASE_LSB 13
`define PRAD_PAGE_BYTES 4096
// Offset window bounds (13-bit offset within region)
`define PRAD_SCU_LO 13'h0000
`define PRAD_SCU_HI 13'h00fc
`define PRAD_IFC_LO 13'h0100
`define PRAD_IFC_HI 13'h01ff
`define PRAD_GTM_LO 13'h0200
`define PRAD_GTM_HI 13'h02ff
`define PRAD_UNA_LO 13'h0300
`define PRAD_UNA_HI 13'h05ff
`define PRAD_PTM_LO 13'h0600
`define PRAD_PTM_HI 13'h06ff
`define PRAD_RSV_LO 13'h0700
`define PRAD_RSV_HI 13'h0fff
`define PRAD_DST_LO 13'h1000
`define PRAD_DST_HI 13'h1fff
// Transfer size codes
`define PRAD_SZ_BYTE 2'h0
`define PRAD_SZ_HALF 2'h1
`define PRAD_SZ_WORD 2'h2
`define PRAD_SZ_DWORD 2'h3
// Target select codes
`define PRAD_TGT_NONE 3'h0
`define PRAD_TGT_SCU 3'h1
`define PRAD_TGT_IFC 3'h2
`define PRAD_TGT_GTM 3'h3
`define PRAD_TGT_PTM 3'h4
`define PRAD_TGT_DST 3'h5
`define PRAD_TGT_RSV 3'h6
// Response codes
`define PRAD_RESP_OKAY 2'h0
`define PRAD_RESP_SLVERR 2'h2
`endif

/* File: prad_tgt_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Peripheral side: answers done after delay_in wait cycles
module prad_tgt_model (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic valid_in,
	input wire logic [11:0] offset_in,
	input wire logic [3:0] delay_in,
	output logic done_out,
	output logic [31:0] rdata_out
);
	logic [3:0] cnt_reg;
	wire logic fire = valid_in && !done_out && cnt_reg == delay_in;
	// One-cycle done; data toggles outside it so stale data never passes
	always @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cnt_reg <= 4'h0;
			done_out <= 1'b0;
			rdata_out <= 32'h0;
		end else begin
			done_out <= fire;
			rdata_out <= fire ? {20'h5a5a0, offset_in} : ~rdata_out;
			cnt_reg <= valid_in && !done_out && !fire ? cnt_reg + 4'h1 : 4'h0;
		end
	end
endmodule // prad_tgt_model
`default_nettype wire
